// File: rtl/tll_pkg.sv
// constants shared by both ends of the three-wire latch loader
// Contract
// - device samples data on every serial clock rise
// - strobe rise moves last 24 bits to latch
// - host serial clock at most 20 MHz
// - host lowers strobe before shifting new word
// - host sends word as three bytes
// - host raises strobe after third byte completes
// - host data stable at sampling rise edge
// - chip enable controls power-down
// - monitor output reports lock, host polls it
// - select bits one-zero load feedback latch
// - select bits zero-one load reference latch
// - shifting and latching continue during power-down
package tll_pkg;
    localparam int WORD_BITS = 24;
    localparam int BYTE_BITS = 8;
    localparam int BYTES_PER_WORD = 3;
    localparam int CNT_W = 5;
    // select field sits in bits [1:0]
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    localparam logic [23:0] LATCH_RST = 24'h000000;
    localparam int REF_CLK_HZ = 20_000_000;
    localparam int MAX_SCLK_HZ = 20_000_000;
    // one serial clock phase lasts at least this many ref_clk cycles
    localparam int MIN_HALF_CYC = (REF_CLK_HZ + 2 * MAX_SCLK_HZ - 1) / (2 * MAX_SCLK_HZ);
    localparam int DEF_HALF_CYC = 2;
endpackage

// File: rtl/tll_if.sv
// three-wire link between host and synthesizer port
`timescale 1ns/1ns
interface tll_if;
    logic sclk;
    logic sdata;
    logic latch_strobe;
    logic chip_en;
    logic monitor_output;
    modport host (output sclk, output sdata, output latch_strobe, output chip_en,
        input monitor_output);
    modport dev (input sclk, input sdata, input latch_strobe, input chip_en,
        output monitor_output);
endinterface

// File: rtl/tll_device.sv
// device end: serial shift register and latch bank
`timescale 1ns/1ns
module tll_device (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    tll_if.dev link, // serial link
    input wire logic lock_in, // lock state from loop logic
    input wire logic mon_lock_sel, // route lock onto monitor output
    output logic [23:0] ctrl_latch, // control latch
    output logic [23:0] ref_latch, // reference-divider latch
    output logic [23:0] fb_latch, // feedback-divider latch
    output logic [23:0] test_latch, // test latch
    output logic load_pulse, // one cycle per latch transfer
    output logic powered_down // power-down state
);
    typedef struct packed {
        logic sclk_q;
        logic le_q;
        logic [23:0] shreg;
        logic [23:0] ctrl;
        logic [23:0] refd;
        logic [23:0] fb;
        logic [23:0] test;
        logic load;
        logic pd;
        logic mon;
    } tll_dev_st_t;
    tll_dev_st_t st_r, st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sclk_q = link.sclk;
        st_nxt.le_q = link.latch_strobe;
        st_nxt.load = 1'b0;
        st_nxt.pd = ~link.chip_en;
        st_nxt.mon = mon_lock_sel & lock_in & link.chip_en;
        // shifting runs regardless of power-down
        if (link.sclk && !st_r.sclk_q)
        begin
            st_nxt.shreg = {st_r.shreg[22:0], link.sdata};
        end
        if (link.latch_strobe && !st_r.le_q)
        begin
            st_nxt.load = 1'b1;
            case (st_r.shreg[tll_pkg::SEL_LSB +: tll_pkg::SEL_W])
                tll_pkg::SEL_CONTROL: st_nxt.ctrl = st_r.shreg;
                tll_pkg::SEL_REF: st_nxt.refd = st_r.shreg;
                tll_pkg::SEL_FEEDBACK: st_nxt.fb = st_r.shreg;
                tll_pkg::SEL_TEST: st_nxt.test = st_r.shreg;
                default: st_nxt.load = 1'b0;
            endcase
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            // strobe idles high, so a low reset value would fake a rise
            st_r.le_q <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign link.monitor_output = st_r.mon;
    assign ctrl_latch = st_r.ctrl;
    assign ref_latch = st_r.refd;
    assign fb_latch = st_r.fb;
    assign test_latch = st_r.test;
    assign load_pulse = st_r.load;
    assign powered_down = st_r.pd;
endmodule

// File: rtl/tll_host.sv
// host end: writes 24-bit words as three bytes over the link
`timescale 1ns/1ns
module tll_host #(
    parameter int HALF_CYC = tll_pkg::DEF_HALF_CYC // ref_clk cycles per sclk phase
) (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    tll_if.host link, // serial link
    input wire logic wr_valid, // word write request
    output logic wr_ready, // accepts request
    input wire logic [23:0] wr_word, // word, select bits in [1:0]
    input wire logic chip_en_in, // power control from user
    output logic locked // polled monitor output
);
    if (HALF_CYC < tll_pkg::MIN_HALF_CYC || HALF_CYC > 255)
    begin : g_bad_half
        $error("HALF_CYC out of range");
    end
    typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_DONE} tll_hst_state_t;
    typedef struct packed {
        tll_hst_state_t state;
        logic [7:0] div;
        logic [4:0] nbit;
        logic [23:0] sh;
        logic sclk;
        logic sdata;
        logic le;
        logic ce;
        logic lk;
    } tll_hst_st_t;
    tll_hst_st_t st_r, st_nxt;
    localparam logic [7:0] HC = 8'(HALF_CYC - 1);
    localparam logic [4:0] LAST = 5'(tll_pkg::WORD_BITS - 1);
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ce = chip_en_in;
        st_nxt.lk = link.monitor_output;
        if (st_r.div != 8'h00)
            st_nxt.div = st_r.div - 8'h01;
        case (st_r.state)
            S_IDLE:
            begin
                if (wr_valid)
                begin
                    st_nxt.le = 1'b0;
                    st_nxt.sh = wr_word;
                    st_nxt.sdata = wr_word[23];
                    st_nxt.nbit = 5'h00;
                    st_nxt.div = HC;
                    st_nxt.state = S_LOW;
                end
            end
            S_LOW:
            begin
                if (st_r.div == 8'h00)
                begin
                    st_nxt.sclk = 1'b1;
                    st_nxt.div = HC;
                    st_nxt.state = S_HIGH;
                end
            end
            S_HIGH:
            begin
                if (st_r.div == 8'h00)
                begin
                    st_nxt.sclk = 1'b0;
                    st_nxt.div = HC;
                    st_nxt.sh = {st_r.sh[22:0], 1'b0};
                    st_nxt.sdata = st_r.sh[22];
                    st_nxt.nbit = st_r.nbit + 5'h01;
                    // three whole bytes, msb first
                    st_nxt.state = (st_r.nbit == LAST) ? S_DONE : S_LOW;
                end
            end
            S_DONE:
            begin
                if (st_r.div == 8'h00)
                begin
                    st_nxt.le = 1'b1;
                    st_nxt.state = S_IDLE;
                end
            end
            default: st_nxt.state = S_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.le <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign wr_ready = (st_r.state == S_IDLE);
    assign link.sclk = st_r.sclk;
    assign link.sdata = st_r.sdata;
    assign link.latch_strobe = st_r.le;
    assign link.chip_en = st_r.ce;
    assign locked = st_r.lk;
endmodule

// File: bench/tll_link_assertions.sv
// wire-level checks for the three-wire latch loader
`timescale 1ns/1ns
module tll_link_assertions (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic sclk, // serial clock
    input wire logic sdata, // serial data
    input wire logic latch_strobe, // load strobe
    input wire logic chip_en, // power control
    input wire logic monitor_output // lock report
);
    logic [4:0] bits_r;
    // cleared while strobe is high, so it still holds the count at the rise
    always_ff @(posedge ref_clk)
        bits_r <= (sys_rst || latch_strobe) ? 5'h00 : bits_r + 5'($rose(sclk));
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    idle_low_a: assert property (latch_strobe |-> !sclk) else $error("sclk high in idle");
    data_hold_a: assert property ($rose(sclk) |-> $stable(sdata)) else $error("sdata moved");
    high_phase_a: assert property ($rose(sclk) |=> sclk) else $error("short high");
    low_phase_a: assert property ($fell(sclk) |=> !sclk) else $error("short low");
    word_len_a:
        assert property ($rose(latch_strobe) |-> bits_r == 5'd24) else $error("bad count");
    bit_cap_a: assert property ($rose(sclk) |-> bits_r < 5'd24) else $error("extra bit");
    load_soon_a:
        assert property (bits_r == 5'd24 && $fell(sclk) |-> ##[1:8] $rose(latch_strobe))
            else $error("no strobe");
    mon_off_a: assert property (!chip_en |=> !monitor_output) else $error("monitor on");
    cover property ($rose(latch_strobe));
    cover property (!chip_en && $rose(latch_strobe));
    cover property ($rose(monitor_output));
endmodule

// File: bench/three_wire_latch_loader_test.sv
// bench joining host and device ends of the latch loader
`timescale 1ns/1ns
module three_wire_latch_loader_test;
    logic ref_clk = 1'b0, sys_rst = 1'b1, wr_valid = 1'b0, chip_en_in = 1'b1;
    logic lock_in = 1'b1, mon_lock_sel = 1'b1, wr_ready, locked, powered_down;
    logic load_pulse;
    int loads = 0;
    logic [23:0] wr_word = 24'h000000, shadow, w;
    wire [23:0] lat [4];
    int bad_count = 0, checks_done = 0;
    tll_if tll_if_inst ();
    tll_host tll_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(tll_if_inst.host),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
        .chip_en_in(chip_en_in), .locked(locked));
    tll_device tll_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(tll_if_inst.dev),
        .lock_in(lock_in), .mon_lock_sel(mon_lock_sel), .ctrl_latch(lat[0]),
        .ref_latch(lat[1]), .fb_latch(lat[2]), .test_latch(lat[3]), .load_pulse(load_pulse),
        .powered_down(powered_down));
    tll_link_assertions tll_link_assertions_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sclk(tll_if_inst.sclk), .sdata(tll_if_inst.sdata),
        .latch_strobe(tll_if_inst.latch_strobe), .chip_en(tll_if_inst.chip_en),
        .monitor_output(tll_if_inst.monitor_output));
    // own view of the wire, msb first
    always @(posedge tll_if_inst.sclk)
        shadow <= {shadow[22:0], tll_if_inst.sdata};
    // one transfer pulse per written word, none from reset
    always @(posedge ref_clk)
        if (load_pulse === 1'b1)
            loads <= loads + 1;
    initial forever #25 ref_clk = ~ref_clk;
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t: %h not %h", $time, got, exp);
        end
    endtask
    // one word; returns once the latch has had time to load
    task automatic wr(input logic [23:0] word);
        @(posedge ref_clk);
        #1;
        wr_valid = 1'b1;
        wr_word = word;
        @(posedge ref_clk);
        #1;
        wr_valid = 1'b0;
        for (int n = 0; n < 200 && wr_ready !== 1'b1; n++)
            @(posedge ref_clk);
        if (wr_ready !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED %0t: host never ready", $time);
            wrap_up();
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #150000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            w = {4'(s), 18'h2a5c3, 2'(s)};
            wr(w);
            chk(lat[s], w);
            chk(shadow, w);
        end
        chk({23'h0, locked}, 24'h000001);
        $display("test 1 end");
        chip_en_in = 1'b0;
        wr(24'h3c96a2);
        chk(lat[2], 24'h3c96a2);
        chk({23'h0, powered_down}, 24'h000001);
        chk({23'h0, locked}, 24'h000000);
        chk(24'(loads), 24'h000005);
        $display("test 2 end");
        wrap_up();
    end
endmodule
